// >>> hw/qrf_defines.svh
// register offsets, field positions, codes and reset values of the receive formatter
`ifndef QRF_DEFINES_SVH
`define QRF_DEFINES_SVH

// register byte offsets
`define QRF_OFS_CTRL      4'h0
`define QRF_OFS_STATUS    4'h4
`define QRF_OFS_PKTCNT    4'h8
`define QRF_OFS_LASTTOK   4'hc
`define QRF_AW            4

// control and status bits
`define QRF_CTRL_EN       0
`define QRF_CTRL_RST      32'h0000_0001
`define QRF_STAT_BUSY     0
`define QRF_STAT_MISAL    1

// token fields (bit 31 is the first bit on the wire)
`define QRF_TOK_ACK_LSB   0
`define QRF_TOK_TC_LSB    4
`define QRF_TOK_CNT_LSB   8
`define QRF_TOK_SPD_LSB   16
`define QRF_TOK_PC        18

// packet-control half of the destination word
`define QRF_PC_PRI_LSB    0
`define QRF_PC_TC_LSB     4
`define QRF_PC_RT_LSB     8
`define QRF_PC_TL_LSB     10

// transaction codes
`define QRF_TC_WRQ_QUAD   4'h0
`define QRF_TC_RDRSP_QUAD 4'h6
`define QRF_TC_LOCK_RSP   4'hb

// quadlet counts
`define QRF_HDR_QUADS     8'h00
`define QRF_ONE_QUAD      8'h01
`define QRF_ALIGN_MASK    2'h3

`endif

// >>> hw/qrf_pkg.sv
// types shared by the receive formatter modules
package qrf_pkg;
  typedef enum logic [5:0] {
    QRF_IDLE  = 6'b000001,
    QRF_TOKEN = 6'b000010,
    QRF_DEST  = 6'b000100,
    QRF_SRC   = 6'b001000,
    QRF_OFFLO = 6'b010000,
    QRF_DATA  = 6'b100000
  } qrf_state_t;

  typedef logic [31:0] qrf_quad_t;
  typedef logic [15:0] qrf_id_t;
  typedef logic [1:0]  qrf_speed_t;
  typedef logic [3:0]  qrf_code_t;
endpackage

// >>> hw/qrf_reg_if.sv
// register access channel between the bus slave and the formatter core
interface qrf_reg_if;
  logic                 wr_en;
  logic [3:0]           wr_addr;
  qrf_pkg::qrf_quad_t   wr_data;
  logic [3:0]           rd_addr;
  qrf_pkg::qrf_quad_t   rd_data;

  modport slave (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport core  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> hw/qrf_ahb_slave.sv
// zero-wait AHB-Lite slave that turns bus transfers into register strobes
`include "qrf_defines.svh"
module qrf_ahb_slave (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire qrf_pkg::qrf_quad_t hwdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output qrf_pkg::qrf_quad_t      hrdata,
  // register channel
  qrf_reg_if.slave                regs
);
  import qrf_pkg::*;

  logic                   wr_pend;
  logic [`QRF_AW-1:0]     wr_idx;
  logic                   take;

  // only NONSEQ/SEQ with the bus ready starts a transfer
  assign take          = hsel && hready && htrans[1];
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign regs.rd_addr  = haddr[`QRF_AW-1:0];
  assign regs.wr_en    = wr_pend;
  assign regs.wr_addr  = wr_idx;
  // hsize is not checked: only whole words are mapped
  assign regs.wr_data  = hwdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= '0;
      hrdata  <= '0;
    end else begin
      wr_pend <= take && hwrite;
      if (take) begin
        wr_idx <= haddr[`QRF_AW-1:0];
      end
      // read data is captured in the address phase so it stands in the data phase
      if (take && !hwrite) begin
        hrdata <= regs.rd_data;
      end
    end
  end
endmodule // qrf_ahb_slave

// >>> hw/qrf_top.sv
// quadlet receive formatter: packs received quadlet packets into the receive fifo
//
// Contract
// RULE1: token is always the first stored quadlet
// RULE2: destination ID high, packet control low
// RULE3: source ID high, offset high low, offset low next
// RULE4: data quadlet only for write request, read response
// RULE5: packet-complete set when next block is last; the code sets it when rx_more_blocks is low, so on the last block itself
// RULE6: speed code 00/01/10, 11 undefined
// RULE7: data quadlet count written into the token
// RULE8: transaction code in token and control word
// RULE9: token carries acknowledge code returned to sender
// RULE10: destination is 10-bit bus, 6-bit node
// RULE11: transaction label passed through unchanged
// RULE12: retry code reported as two bits
// RULE13: sender puts zero priority; passed through
// RULE14: destination offset quadlet aligned, modulo four
// RULE15: lock response: rcode top four, rest reserved
// RULE16: source ID is the sending node
// RULE17: quadlets of one packet stored contiguously, in order
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`include "qrf_defines.svh"
module qrf_top (
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite register bus
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic               hready,
  input  wire qrf_pkg::qrf_quad_t hwdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output qrf_pkg::qrf_quad_t      hrdata,
  // received packet from the link receiver
  input  wire logic               rx_valid,
  output logic                    rx_ready,
  input  wire qrf_pkg::qrf_id_t   rx_dest_id,
  input  wire qrf_pkg::qrf_id_t   rx_src_id,
  input  wire logic [5:0]         rx_tlabel,
  input  wire logic [1:0]         rx_retry,
  input  wire qrf_pkg::qrf_code_t rx_tcode,
  input  wire qrf_pkg::qrf_code_t rx_priority,
  input  wire logic [15:0]        rx_offset_high,
  input  wire qrf_pkg::qrf_quad_t rx_offset_low,
  input  wire qrf_pkg::qrf_quad_t rx_data,
  input  wire qrf_pkg::qrf_speed_t rx_speed,
  input  wire qrf_pkg::qrf_code_t rx_ack_sent,
  input  wire logic               rx_more_blocks,
  // receive fifo write side
  output logic                    fifo_wvalid,
  input  wire logic               fifo_wready,
  output qrf_pkg::qrf_quad_t      fifo_wdata,
  output logic                    fifo_wlast
);
  import qrf_pkg::*;

  qrf_reg_if regs ();

  qrf_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs)
  );

  // ---------------- registers ----------------
  qrf_quad_t   ctrl;
  logic        misaligned;
  qrf_quad_t   pkt_count;
  qrf_quad_t   last_token;
  qrf_state_t  state;
  qrf_state_t  next_state;

  logic        enable;
  logic        busy;
  logic        wr_ctrl;
  logic        wr_status;
  logic        clr_misal;
  qrf_quad_t   status_word;

  assign enable      = ctrl[`QRF_CTRL_EN];
  assign busy        = (state != QRF_IDLE);
  assign wr_ctrl     = regs.wr_en && (regs.wr_addr == `QRF_OFS_CTRL);
  assign wr_status   = regs.wr_en && (regs.wr_addr == `QRF_OFS_STATUS);
  assign clr_misal   = wr_status && regs.wr_data[`QRF_STAT_MISAL];

  always_comb begin
    status_word = '0;
    status_word[`QRF_STAT_BUSY]  = busy;
    status_word[`QRF_STAT_MISAL] = misaligned;
  end

  // read decode, unmapped offsets read zero
  assign regs.rd_data = (regs.rd_addr == `QRF_OFS_CTRL)    ? ctrl :
                        (regs.rd_addr == `QRF_OFS_STATUS)  ? status_word :
                        (regs.rd_addr == `QRF_OFS_PKTCNT)  ? pkt_count :
                        (regs.rd_addr == `QRF_OFS_LASTTOK) ? last_token : '0;

  // ---------------- packet capture ----------------
  logic        accept;
  logic        fifo_take;
  logic        has_data;
  logic        lock_rsp;
  logic        off_bad;
  logic [7:0]  data_count;
  logic [15:0] off_high;
  logic [15:0] pkt_control;
  qrf_quad_t   token;
  qrf_quad_t   quad [0:4];
  logic        keep_data;

  assign rx_ready  = enable && !busy;
  assign accept    = rx_valid && rx_ready;
  assign fifo_take = fifo_wvalid && fifo_wready;

  assign has_data   = (rx_tcode == `QRF_TC_WRQ_QUAD) ||
                      (rx_tcode == `QRF_TC_RDRSP_QUAD);                  // RULE4
  assign data_count = has_data ? `QRF_ONE_QUAD : `QRF_HDR_QUADS;          // RULE7
  assign lock_rsp   = (rx_tcode == `QRF_TC_LOCK_RSP);
  // reserved offset bits of a lock response are stored as zero
  assign off_high   = lock_rsp ? {rx_offset_high[15:12], 12'h000}
                               : rx_offset_high;                          // RULE15
  assign off_bad    = (rx_offset_low[1:0] & `QRF_ALIGN_MASK) != 2'h0;     // RULE14

  always_comb begin
    token = '0;
    token[`QRF_TOK_ACK_LSB +: 4] = rx_ack_sent;                           // RULE9
    token[`QRF_TOK_TC_LSB  +: 4] = rx_tcode;                              // RULE8
    token[`QRF_TOK_CNT_LSB +: 8] = data_count;                            // RULE7
    token[`QRF_TOK_SPD_LSB +: 2] = rx_speed;                              // RULE6
    token[`QRF_TOK_PC]           = !rx_more_blocks;                       // RULE5
  end

  always_comb begin
    pkt_control = '0;
    pkt_control[`QRF_PC_PRI_LSB +: 4] = rx_priority;                      // RULE13
    pkt_control[`QRF_PC_TC_LSB  +: 4] = rx_tcode;                         // RULE8
    pkt_control[`QRF_PC_RT_LSB  +: 2] = rx_retry;                         // RULE12
    pkt_control[`QRF_PC_TL_LSB  +: 6] = rx_tlabel;                        // RULE11
  end

  // the whole packet is latched at once so the fifo can stall without
  // holding the link receiver; the price is five words of storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 5; i++) begin
        quad[i] <= '0;
      end
      keep_data <= 1'b0;
    end else if (accept) begin
      quad[0]   <= token;                                                 // RULE1
      quad[1]   <= {rx_dest_id, pkt_control};                             // RULE2 RULE10
      quad[2]   <= {rx_src_id, off_high};                                 // RULE3 RULE16
      quad[3]   <= rx_offset_low;                                         // RULE3
      quad[4]   <= rx_data;
      keep_data <= has_data;                                              // RULE4
    end
  end

  // ---------------- fifo sequencer ----------------
  always_comb begin
    next_state = state;
    case (state)
      QRF_IDLE:  if (accept) next_state = QRF_TOKEN;                      // RULE1
      QRF_TOKEN: if (fifo_take) next_state = QRF_DEST;                    // RULE17
      QRF_DEST:  if (fifo_take) next_state = QRF_SRC;
      QRF_SRC:   if (fifo_take) next_state = QRF_OFFLO;
      QRF_OFFLO: if (fifo_take) next_state = keep_data ? QRF_DATA : QRF_IDLE; // RULE4
      QRF_DATA:  if (fifo_take) next_state = QRF_IDLE;
      default:   next_state = QRF_IDLE;
    endcase
  end

  qrf_quad_t next_wdata;
  logic      next_wlast;

  always_comb begin
    next_wdata = fifo_wdata;
    next_wlast = 1'b0;
    case (next_state)
      QRF_TOKEN: next_wdata = quad[0];
      QRF_DEST:  next_wdata = quad[1];
      QRF_SRC:   next_wdata = quad[2];
      QRF_OFFLO: begin
        next_wdata = quad[3];
        next_wlast = !keep_data;
      end
      QRF_DATA: begin
        next_wdata = quad[4];
        next_wlast = 1'b1;
      end
      default:   next_wdata = fifo_wdata;
    endcase
  end

  // token is loaded straight from the token word, not from quad[0], so it appears one cycle after accept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= QRF_IDLE;
      fifo_wdata  <= '0;
      fifo_wlast  <= 1'b0;
      fifo_wvalid <= 1'b0;
    end else begin
      state       <= next_state;
      fifo_wvalid <= (next_state != QRF_IDLE);
      fifo_wlast  <= accept ? 1'b0 : next_wlast;
      fifo_wdata  <= accept ? token : next_wdata;                         // RULE1 RULE17
    end
  end

  // ---------------- software-visible state ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl       <= `QRF_CTRL_RST;
      misaligned <= 1'b0;
      pkt_count  <= '0;
      last_token <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= regs.wr_data;
      end
      // a new misaligned packet wins over a clear in the same cycle
      if (accept && off_bad) begin
        misaligned <= 1'b1;                                               // RULE14
      end else if (clr_misal) begin
        misaligned <= 1'b0;
      end
      if (accept) begin
        pkt_count  <= pkt_count + 32'h0000_0001;
        last_token <= token;
      end
    end
  end
endmodule // qrf_top

// >>> verif/qrf_checker.sv
// concurrent checks on the receive formatter fifo side
module qrf_checker (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                rx_valid,
  input wire logic                rx_ready,
  input wire qrf_pkg::qrf_code_t  rx_tcode,
  input wire qrf_pkg::qrf_speed_t rx_speed,
  input wire qrf_pkg::qrf_code_t  rx_ack_sent,
  input wire logic                rx_more_blocks,
  input wire logic                fifo_wvalid,
  input wire logic                fifo_wready,
  input wire qrf_pkg::qrf_quad_t  fifo_wdata,
  input wire logic                fifo_wlast
);
  timeunit 1ns;
  timeprecision 1ps;
  import qrf_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       acc;
  logic       hs;
  logic       dat_now;
  logic       dat;
  logic [2:0] idx;
  assign acc = rx_valid && rx_ready;
  assign hs = fifo_wvalid && fifo_wready;
  assign dat_now = rx_tcode == 4'h0 || rx_tcode == 4'h6;
  // quadlet index within the packet, restarted at every accept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx <= 3'h0;
      dat <= 1'b0;
    end else if (acc) begin
      idx <= 3'h0;
      dat <= dat_now;
    end else if (hs) begin
      idx <= idx + 3'h1;
    end
  end
  token_first_a: assert property (acc |=> fifo_wvalid && !fifo_wlast && fifo_wdata[31:19] == 13'h0)
    else $error("token not first after accept");
  token_code_a: assert property (acc |=> fifo_wdata[7:4] == $past(rx_tcode))
    else $error("token transaction code wrong");
  token_ack_a: assert property (acc |=> fifo_wdata[3:0] == $past(rx_ack_sent))
    else $error("token ack code wrong");
  token_speed_a: assert property (acc |=> fifo_wdata[17:16] == $past(rx_speed))
    else $error("token speed wrong");
  token_done_a: assert property (acc |=> fifo_wdata[18] == !$past(rx_more_blocks))
    else $error("packet complete flag wrong");
  token_count_a: assert property (acc |=> fifo_wdata[15:8] == ($past(dat_now) ? 8'h01 : 8'h00))
    else $error("data quadlet count wrong");
  stall_hold_a: assert property (fifo_wvalid && !fifo_wready |=>
    fifo_wvalid && $stable(fifo_wdata) && $stable(fifo_wlast))
    else $error("quadlet changed while stalled");
  no_interleave_a: assert property (fifo_wvalid |-> !rx_ready)
    else $error("accept possible mid packet");
  packet_len_a: assert property (hs && fifo_wlast |-> idx == (dat ? 3'h4 : 3'h3))
    else $error("packet length wrong");
  cover property (acc && dat_now);
  cover property (fifo_wvalid && !fifo_wready);
  cover property (hs && fifo_wlast && !dat);
endmodule // qrf_checker

bind qrf_top qrf_checker chk (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_tcode(rx_tcode), .rx_speed(rx_speed), .rx_ack_sent(rx_ack_sent),
  .rx_more_blocks(rx_more_blocks), .fifo_wvalid(fifo_wvalid), .fifo_wready(fifo_wready),
  .fifo_wdata(fifo_wdata), .fifo_wlast(fifo_wlast));

// >>> verif/qrf_fifo_model.sv
// host-side reader of the receive fifo, prompt or stalling
module qrf_fifo_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               stall_en,
  input  wire logic               fifo_wvalid,
  input  wire qrf_pkg::qrf_quad_t fifo_wdata,
  output logic                    fifo_wready
);
  timeunit 1ns;
  timeprecision 1ps;
  import qrf_pkg::*;
  qrf_quad_t  q[$];
  logic [1:0] ph;
  // slow mode takes one quadlet in four cycles to exercise the hold path
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 2'h0;
      fifo_wready <= 1'b0;
    end else begin
      if (fifo_wvalid && fifo_wready) q.push_back(fifo_wdata);
      ph <= ph + 2'h1;
      fifo_wready <= !stall_en || ph == 2'h3;
    end
  end
endmodule // qrf_fifo_model

// >>> verif/tb_quadlet_receive_formatter.sv
// self-checking bench for the quadlet receive formatter
module tb_quadlet_receive_formatter;
  timeunit 1ns;
  timeprecision 1ps;
  import qrf_pkg::*;
  localparam qrf_id_t DST = 16'h2a7c;
  localparam qrf_id_t SRC = 16'hffc1;
  localparam logic [15:0] OH = 16'hf123;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stall_en = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0, rx_retry = 2'h0;
  logic [2:0]  hsize = 3'h2;
  qrf_quad_t   hwdata = 32'h0, rx_offset_low = 32'h0, rx_data = 32'h0, hrdata, fifo_wdata;
  logic rx_valid = 1'b0, rx_more_blocks = 1'b0, hreadyout, hresp, rx_ready;
  logic fifo_wvalid, fifo_wready, fifo_wlast;
  logic [5:0]  rx_tlabel = 6'h0;
  qrf_code_t   rx_tcode = 4'h0, rx_priority = 4'h0, rx_ack_sent = 4'h0;
  qrf_speed_t  rx_speed = 2'h0;
  wire logic   hready = hreadyout;
  int n_errors = 0, cmp_count = 0;
  qrf_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_dest_id(DST), .rx_src_id(SRC), .rx_tlabel(rx_tlabel), .rx_retry(rx_retry),
    .rx_tcode(rx_tcode), .rx_priority(rx_priority), .rx_offset_high(OH),
    .rx_offset_low(rx_offset_low), .rx_data(rx_data), .rx_speed(rx_speed),
    .rx_ack_sent(rx_ack_sent), .rx_more_blocks(rx_more_blocks), .fifo_wvalid(fifo_wvalid),
    .fifo_wready(fifo_wready), .fifo_wdata(fifo_wdata), .fifo_wlast(fifo_wlast));
  qrf_fifo_model fifo (.hclk(hclk), .hresetn(hresetn), .stall_en(stall_en),
    .fifo_wvalid(fifo_wvalid), .fifo_wdata(fifo_wdata), .fifo_wready(fifo_wready));
  always #20 hclk = ~hclk;
  task automatic chk(string what, qrf_quad_t exp, qrf_quad_t got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single word transfer, entered right after a rising edge
  // waits as long as the slave needs; only the watchdog ends a hung transfer
  task automatic bus(logic wr, logic [31:0] a, qrf_quad_t d, output qrf_quad_t r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    r = hrdata;
    chk("hresp okay", 32'h0, {31'h0, hresp});
  endtask
  task automatic send(qrf_code_t tc, qrf_speed_t sp, logic [1:0] rt, logic more, qrf_quad_t olo);
    int k = 0;
    int n;
    qrf_quad_t e[5];
    n = (tc == 4'h0 || tc == 4'h6) ? 5 : 4;
    e[0] = {13'h0, !more, sp, 7'h0, n == 5, tc, tc ^ 4'h3};
    e[1] = {DST, tc, rt, rt, tc, 4'h0};
    e[2] = {SRC, tc == 4'hb ? {OH[15:12], 12'h0} : OH};
    e[3] = olo;
    e[4] = ~olo;
    fifo.q.delete();
    rx_tcode <= tc;
    rx_speed <= sp;
    rx_retry <= rt;
    rx_tlabel <= {tc, rt};
    rx_ack_sent <= tc ^ 4'h3;
    rx_more_blocks <= more;
    rx_offset_low <= olo;
    rx_data <= ~olo;
    rx_valid <= 1'b1;
    do @(posedge hclk); while (!rx_ready && k++ < 50);
    rx_valid <= 1'b0;
    while (fifo.q.size() < n && k++ < 200) @(posedge hclk);
    repeat (3) @(posedge hclk);
    chk("packet length", 32'(n), 32'(fifo.q.size()));
    for (int j = 0; j < n; j++) chk("quadlet", e[j], fifo.q[j]);
  endtask
  task automatic t_regs();
    qrf_quad_t r;
    bus(1'b0, 32'h0, 32'h0, r);
    chk("ctrl reset", 32'h1, r);
    bus(1'b0, 32'h8, 32'h0, r);
    chk("pktcnt reset", 32'h0, r);
    // only haddr[3:0] is decoded, so 0x10 aliases the control word
    bus(1'b0, 32'h10, 32'h0, r);
    chk("ctrl alias read", 32'h1, r);
    $display("test regs done");
  endtask
  task automatic t_stream();
    qrf_code_t tcs[8] = '{4'h0, 4'h1, 4'h4, 4'h6, 4'hb, 4'h0, 4'h6, 4'h1};
    for (int i = 0; i < 8; i++) begin
      stall_en <= i[2];
      send(tcs[i], qrf_speed_t'(i % 3), i[1:0], i[0], {i[7:0], 24'h3c5a00});
    end
    $display("test stream done");
  endtask
  task automatic t_gate();
    qrf_quad_t r;
    bus(1'b1, 32'h0, 32'h0, r);
    rx_valid <= 1'b1;
    repeat (6) @(posedge hclk);
    chk("gated ready", 32'h0, {30'h0, rx_ready, fifo_wvalid});
    rx_valid <= 1'b0;
    bus(1'b1, 32'h0, 32'h1, r);
    $display("test gate done");
  endtask
  task automatic t_align();
    qrf_quad_t r;
    stall_en <= 1'b0;
    send(4'h1, 2'h2, 2'h3, 1'b0, 32'h1000_0002);
    bus(1'b0, 32'h4, 32'h0, r);
    chk("misalign flag", 32'h2, r);
    bus(1'b1, 32'h4, 32'h2, r);
    bus(1'b0, 32'h4, 32'h0, r);
    chk("flag cleared", 32'h0, r);
    bus(1'b0, 32'h8, 32'h0, r);
    chk("packet count", 32'h9, r);
    bus(1'b0, 32'hc, 32'h0, r);
    chk("last token", {13'h0, 1'b1, 2'h2, 8'h0, 4'h1, 4'h2}, r);
    $display("test align done");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 40);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_stream();
    t_gate();
    t_align();
    tally_and_finish();
  end
endmodule // tb_quadlet_receive_formatter
